// File: rtl/bac_device.sv
// Adapter end: configuration command decoder and parameter store
// Notes on behaviour
// - Host runs search with accelerator on/off codes
// - Sixteen bytes in, sixteen out per pass
// - Reset loads default code into every parameter
// - 3-bit parameter code selects 3-bit value
// - Write byte: 0, param, value, 1
// - Read byte: 0000, param, 1
// - Response bit 0 clear; write echoes upper seven
// - Read returns value code, echoes upper four
// - Defaults 15V/us, 512us, 524ms, 9.6k, 8us, 3us
// - Duration and timing codes map as tabled
// - Slew codes map to eight falling rates
// - Baud codes map to four serial rates
// - Baud codes 100-111 invert receive polarity
// - Response to baud change uses new rate
// - Terminate code ends pulse in command mode
// - Unlimited pulse only when staying command mode
// - Host never writes pullup code 110
// - Flexible equals standard while parameters default
// - Sample offset and recovery share one parameter
// - Rising edge shaping always enabled
// - Fall slew limit only flexible, non-default
`timescale 1ns/1ps
module bac_device (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  // Bus timing engine status
  input wire logic I_FLEX_SPEED,
  input wire logic I_PULSE_ACTIVE,
  input wire logic I_BUS_RSP_VALID,
  input wire logic [7:0] I_BUS_RSP_BYTE,
  // Pin level
  input wire logic I_SERIAL_POLARITY_SELECT_PIN,
  // Bus timing engine controls
  output logic O_DATA_MODE,
  output logic O_SEARCH_ACCEL,
  output logic O_BUS_BYTE_VALID,
  output logic [7:0] O_BUS_BYTE,
  output logic O_PULSE_TERMINATE,
  output logic [2:0] O_FALLDOWN_EDGE_RATE_PARAM,
  output logic [2:0] O_PROGRAM_PULSE_LENGTH_PARAM,
  output logic [2:0] O_STRONG_PULLUP_LENGTH_PARAM,
  output logic [2:0] O_WRITE_ONE_LOW_PARAM,
  output logic [2:0] O_SAMPLE_OFFSET_RECOVERY_PARAM,
  output logic [2:0] O_PULLDOWN_LOAD_PARAM,
  output logic [2:0] O_HOST_SERIAL_RATE_PARAM,
  output logic O_FLEX_TIMING_EN,
  output logic O_FALL_SLEW_LIMIT_EN,
  output logic O_RISE_SHAPE_EN,
  output logic O_PROG_UNLIMITED,
  output logic O_SPU_UNLIMITED,
  // Host serial side
  output logic [1:0] O_SERIAL_RATE_SEL,
  output logic O_RXD_INVERT,
  // Link
  bac_link_if.dev link
);
  localparam logic [2:0] DEFAULTS [8] = '{bac_pkg::DEF_UNUSED, bac_pkg::DEF_SLEW,
    bac_pkg::DEF_PROG, bac_pkg::DEF_SPU, bac_pkg::DEF_W1LOW, bac_pkg::DEF_SAMPLE,
    bac_pkg::DEF_LOAD, bac_pkg::DEF_BAUD};

  logic [2:0] param_store [8];
  logic cmd_mode_byte;
  logic data_mode_byte;
  logic is_config;
  logic is_read;
  logic is_write;
  logic [2:0] par_code;
  logic [2:0] val_code;
  logic [2:0] read_value;
  logic [7:0] next_rsp_byte;

  always_comb begin
    cmd_mode_byte = link.cmd_valid && !O_DATA_MODE;
    data_mode_byte = link.cmd_valid && O_DATA_MODE;
    par_code = link.cmd_byte[bac_pkg::PAR_HI:bac_pkg::PAR_LO];
    val_code = link.cmd_byte[bac_pkg::VAL_HI:bac_pkg::VAL_LO];
    is_config = cmd_mode_byte && !link.cmd_byte[bac_pkg::CMD_TYPE_BIT]
      && link.cmd_byte[bac_pkg::CMD_MARK_BIT];
    is_read = is_config && par_code == bac_pkg::PAR_READ;
    is_write = is_config && par_code != bac_pkg::PAR_READ;
    read_value = param_store[val_code];
    if (is_read) begin
      next_rsp_byte = {link.cmd_byte[bac_pkg::CMD_TYPE_BIT:bac_pkg::PAR_LO],
        read_value, 1'b0};
    end else begin
      next_rsp_byte = {link.cmd_byte[bac_pkg::CMD_TYPE_BIT:bac_pkg::VAL_LO], 1'b0};
    end
  end

  // One setting per entry; only the addressed one moves
  generate
    for (genvar p = 0; p < 8; p++) begin : g_store
      always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
          param_store[p] <= DEFAULTS[p];
        end else if (is_write && par_code == 3'(p)) begin
          param_store[p] <= val_code;
        end
      end
    end
  endgenerate

  // Mode, accelerator and terminate handling
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      O_DATA_MODE <= 1'b0;
      O_SEARCH_ACCEL <= 1'b0;
      O_PULSE_TERMINATE <= 1'b0;
    end else begin
      O_PULSE_TERMINATE <= 1'b0;
      if (cmd_mode_byte) begin
        unique case (link.cmd_byte)
          bac_pkg::CODE_DATA_MODE: begin
            O_DATA_MODE <= 1'b1;
          end
          bac_pkg::CODE_ACCEL_ON: begin
            O_SEARCH_ACCEL <= 1'b1;
          end
          bac_pkg::CODE_ACCEL_OFF: begin
            O_SEARCH_ACCEL <= 1'b0;
          end
          bac_pkg::CODE_TERMINATE: begin
            O_PULSE_TERMINATE <= I_PULSE_ACTIVE;
          end
          default: begin
          end
        endcase
      end else if (data_mode_byte && link.cmd_byte == bac_pkg::CODE_CMD_MODE) begin
        O_DATA_MODE <= 1'b0;
      end
    end
  end

  // Data bytes go to the bus engine; no terminate path exists there
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      O_BUS_BYTE_VALID <= 1'b0;
      O_BUS_BYTE <= 8'h00;
    end else begin
      O_BUS_BYTE_VALID <= data_mode_byte && link.cmd_byte != bac_pkg::CODE_CMD_MODE;
      if (data_mode_byte) begin
        O_BUS_BYTE <= link.cmd_byte;
      end
    end
  end

  // Answers; configuration wins over a late bus answer
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      link.rsp_valid <= 1'b0;
      link.rsp_byte <= 8'h00;
      link.rsp_rate <= 2'h0;
    end else begin
      link.rsp_valid <= is_config || I_BUS_RSP_VALID;
      if (is_config) begin
        link.rsp_byte <= next_rsp_byte;
      end else if (I_BUS_RSP_VALID) begin
        link.rsp_byte <= I_BUS_RSP_BYTE;
      end
      // New rate applies already to the answer of the change itself
      if (is_write && par_code == bac_pkg::PAR_BAUD) begin
        link.rsp_rate <= val_code[1:0];
      end else begin
        link.rsp_rate <= param_store[bac_pkg::PAR_BAUD][1:0];
      end
    end
  end

  // Settings presented to the waveform engine
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      O_FALLDOWN_EDGE_RATE_PARAM <= bac_pkg::DEF_SLEW;
      O_PROGRAM_PULSE_LENGTH_PARAM <= bac_pkg::DEF_PROG;
      O_STRONG_PULLUP_LENGTH_PARAM <= bac_pkg::DEF_SPU;
      O_WRITE_ONE_LOW_PARAM <= bac_pkg::DEF_W1LOW;
      O_SAMPLE_OFFSET_RECOVERY_PARAM <= bac_pkg::DEF_SAMPLE;
      O_PULLDOWN_LOAD_PARAM <= bac_pkg::DEF_LOAD;
      O_HOST_SERIAL_RATE_PARAM <= bac_pkg::DEF_BAUD;
      O_PROG_UNLIMITED <= 1'b0;
      O_SPU_UNLIMITED <= 1'b0;
    end else begin
      O_FALLDOWN_EDGE_RATE_PARAM <= param_store[bac_pkg::PAR_SLEW];
      O_PROGRAM_PULSE_LENGTH_PARAM <= param_store[bac_pkg::PAR_PROG];
      O_STRONG_PULLUP_LENGTH_PARAM <= param_store[bac_pkg::PAR_SPU];
      O_WRITE_ONE_LOW_PARAM <= param_store[bac_pkg::PAR_W1LOW];
      // One code drives both sample delay and write-0 recovery
      O_SAMPLE_OFFSET_RECOVERY_PARAM <= param_store[bac_pkg::PAR_SAMPLE];
      O_PULLDOWN_LOAD_PARAM <= param_store[bac_pkg::PAR_LOAD];
      O_HOST_SERIAL_RATE_PARAM <= param_store[bac_pkg::PAR_BAUD];
      O_PROG_UNLIMITED <= param_store[bac_pkg::PAR_PROG] == bac_pkg::VAL_UNLIMITED;
      O_SPU_UNLIMITED <= param_store[bac_pkg::PAR_SPU] == bac_pkg::VAL_UNLIMITED;
    end
  end

  // Edge shaping and speed qualifiers
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      O_FLEX_TIMING_EN <= 1'b0;
      O_FALL_SLEW_LIMIT_EN <= 1'b0;
      O_RISE_SHAPE_EN <= 1'b1;
      O_SERIAL_RATE_SEL <= 2'h0;
      O_RXD_INVERT <= 1'b0;
    end else begin
      O_FLEX_TIMING_EN <= I_FLEX_SPEED
        && (param_store[bac_pkg::PAR_SLEW] != bac_pkg::DEF_SLEW
        || param_store[bac_pkg::PAR_W1LOW] != bac_pkg::DEF_W1LOW
        || param_store[bac_pkg::PAR_SAMPLE] != bac_pkg::DEF_SAMPLE);
      O_FALL_SLEW_LIMIT_EN <= I_FLEX_SPEED
        && param_store[bac_pkg::PAR_SLEW] != bac_pkg::DEF_SLEW;
      O_RISE_SHAPE_EN <= 1'b1;
      O_SERIAL_RATE_SEL <= param_store[bac_pkg::PAR_BAUD][1:0];
      O_RXD_INVERT <= I_SERIAL_POLARITY_SELECT_PIN
        ^ param_store[bac_pkg::PAR_BAUD][bac_pkg::BAUD_INV_BIT];
    end
  end
endmodule

// File: rtl/bac_host.sv
// Host end: builds configuration and accelerator command sequences
`timescale 1ns/1ps
module bac_host (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  // User requests
  input wire logic I_WR_REQ,
  input wire logic [2:0] I_WR_PARAM,
  input wire logic [2:0] I_WR_VALUE,
  input wire logic I_STAY_CMD,
  input wire logic I_RD_REQ,
  input wire logic [2:0] I_RD_PARAM,
  input wire logic I_ACCEL_ON_REQ,
  input wire logic I_ACCEL_OFF_REQ,
  input wire logic I_DATA_REQ,
  input wire logic [7:0] I_DATA_BYTE,
  // User results
  output logic O_BUSY,
  output logic O_REFUSED,
  output logic O_RSP_VALID,
  output logic [7:0] O_RSP_BYTE,
  output logic O_PASS_DONE,
  // Link
  bac_link_if.host link
);
  logic [7:0] queue [3];
  logic [1:0] queue_len;
  logic gap;
  logic accel_on;
  logic [4:0] pass_count;
  logic bad_write;

  // Never program the forbidden pullup code; unlimited only if we stay in command mode
  always_comb begin
    bad_write = (I_WR_PARAM == bac_pkg::PAR_SPU && I_WR_VALUE == bac_pkg::VAL_SPU_FORBIDDEN)
      || ((I_WR_PARAM == bac_pkg::PAR_PROG || I_WR_PARAM == bac_pkg::PAR_SPU)
      && I_WR_VALUE == bac_pkg::VAL_UNLIMITED && !I_STAY_CMD);
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      queue_len <= 2'h0;
      gap <= 1'b0;
      link.cmd_valid <= 1'b0;
      link.cmd_byte <= 8'h00;
      O_REFUSED <= 1'b0;
      accel_on <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        queue[i] <= 8'h00;
      end
    end else begin
      O_REFUSED <= 1'b0;
      link.cmd_valid <= 1'b0;
      if (queue_len != 2'h0) begin
        if (!gap) begin
          link.cmd_valid <= 1'b1;
          link.cmd_byte <= queue[0];
          queue[0] <= queue[1];
          queue[1] <= queue[2];
          queue_len <= queue_len - 2'h1;
        end
        gap <= !gap;
      end else begin
        gap <= 1'b0;
        if (I_WR_REQ) begin
          if (bad_write) begin
            O_REFUSED <= 1'b1;
          end else begin
            queue[0] <= {1'b0, I_WR_PARAM, I_WR_VALUE, 1'b1};
            queue_len <= 2'h1;
          end
        end else if (I_RD_REQ) begin
          queue[0] <= {4'h0, I_RD_PARAM, 1'b1};
          queue_len <= 2'h1;
        end else if (I_ACCEL_ON_REQ) begin
          queue[0] <= bac_pkg::CODE_CMD_MODE;
          queue[1] <= bac_pkg::CODE_ACCEL_ON;
          queue[2] <= bac_pkg::CODE_DATA_MODE;
          queue_len <= 2'h3;
          accel_on <= 1'b1;
        end else if (I_ACCEL_OFF_REQ) begin
          queue[0] <= bac_pkg::CODE_CMD_MODE;
          queue[1] <= bac_pkg::CODE_ACCEL_OFF;
          queue_len <= 2'h2;
          accel_on <= 1'b0;
        end else if (I_DATA_REQ) begin
          queue[0] <= I_DATA_BYTE;
          queue_len <= 2'h1;
        end
      end
    end
  end

  // Sixteen answers close one accelerated pass
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      pass_count <= 5'h00;
      O_PASS_DONE <= 1'b0;
    end else begin
      O_PASS_DONE <= 1'b0;
      if (!accel_on) begin
        pass_count <= 5'h00;
      end else if (link.rsp_valid) begin
        if (pass_count == bac_pkg::SEARCH_BYTES - 5'h01) begin
          pass_count <= 5'h00;
          O_PASS_DONE <= 1'b1;
        end else begin
          pass_count <= pass_count + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      O_RSP_VALID <= 1'b0;
      O_RSP_BYTE <= 8'h00;
      O_BUSY <= 1'b0;
    end else begin
      O_RSP_VALID <= link.rsp_valid;
      if (link.rsp_valid) begin
        O_RSP_BYTE <= link.rsp_byte;
      end
      O_BUSY <= (queue_len != 2'h0) || I_WR_REQ || I_RD_REQ || I_ACCEL_ON_REQ
        || I_ACCEL_OFF_REQ || I_DATA_REQ;
    end
  end
endmodule

// File: rtl/bac_link_if.sv
// Byte link between host end and adapter end
`timescale 1ns/1ps
interface bac_link_if;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic rsp_valid;
  logic [7:0] rsp_byte;
  logic [1:0] rsp_rate;
  modport dev (input cmd_valid, input cmd_byte, output rsp_valid, output rsp_byte,
    output rsp_rate);
  modport host (output cmd_valid, output cmd_byte, input rsp_valid, input rsp_byte,
    input rsp_rate);
endinterface

// File: rtl/bac_pkg.sv
// Shared constants for the adapter configuration command link
package bac_pkg;
  // Configuration command byte layout
  localparam int CMD_TYPE_BIT = 7;
  localparam int CMD_MARK_BIT = 0;
  localparam int PAR_HI = 6;
  localparam int PAR_LO = 4;
  localparam int VAL_HI = 3;
  localparam int VAL_LO = 1;
  localparam logic [2:0] PAR_READ = 3'h0;
  // Parameter codes
  localparam logic [2:0] PAR_SLEW = 3'h1;
  localparam logic [2:0] PAR_PROG = 3'h2;
  localparam logic [2:0] PAR_SPU = 3'h3;
  localparam logic [2:0] PAR_W1LOW = 3'h4;
  localparam logic [2:0] PAR_SAMPLE = 3'h5;
  localparam logic [2:0] PAR_LOAD = 3'h6;
  localparam logic [2:0] PAR_BAUD = 3'h7;
  // Power-on value codes: 15V/us, 512us, 524ms, 8us, 3us, load, 9.6kbps
  localparam logic [2:0] DEF_SLEW = 3'h0;
  localparam logic [2:0] DEF_PROG = 3'h4;
  localparam logic [2:0] DEF_SPU = 3'h4;
  localparam logic [2:0] DEF_W1LOW = 3'h0;
  localparam logic [2:0] DEF_SAMPLE = 3'h0;
  localparam logic [2:0] DEF_LOAD = 3'h0;
  localparam logic [2:0] DEF_BAUD = 3'h0;
  localparam logic [2:0] DEF_UNUSED = 3'h0;
  // Special value codes
  localparam logic [2:0] VAL_UNLIMITED = 3'h7;
  localparam logic [2:0] VAL_SPU_FORBIDDEN = 3'h6;
  localparam int BAUD_INV_BIT = 2;
  // Mode and control command codes
  localparam logic [7:0] CODE_DATA_MODE = 8'h00_E1;
  localparam logic [7:0] CODE_CMD_MODE = 8'h00_E3;
  localparam logic [7:0] CODE_ACCEL_ON = 8'h00_B1;
  localparam logic [7:0] CODE_ACCEL_OFF = 8'h00_A1;
  localparam logic [7:0] CODE_TERMINATE = 8'h00_F1;
  // Bytes in one accelerated search pass
  localparam logic [4:0] SEARCH_BYTES = 5'h1_0;
endpackage

// File: tb/bac_props.sv
// Link checker for the configuration command path
`timescale 1ns/1ps
module bac_props (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  // Link
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic [1:0] rsp_rate
);
  logic dm, wr_q, rd_q, cfg_ok, cfg_wr, cfg_rd, quiet;
  logic [7:0] prev;
  logic [2:0] store [8];
  assign cfg_ok = cmd_valid && !dm && !cmd_byte[7] && cmd_byte[0];
  assign cfg_wr = cfg_ok && (cmd_byte[6:4] != 3'h0);
  assign cfg_rd = cfg_ok && (cmd_byte[6:4] == 3'h0);
  // Mode codes and malformed config bytes must stay silent
  assign quiet = cmd_valid && !dm && ((!cmd_byte[7] && !cmd_byte[0]) ||
    cmd_byte == bac_pkg::CODE_DATA_MODE || cmd_byte == bac_pkg::CODE_CMD_MODE ||
    cmd_byte == bac_pkg::CODE_ACCEL_ON || cmd_byte == bac_pkg::CODE_ACCEL_OFF);
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) dm <= 1'b0;
    else if (cmd_valid && cmd_byte == bac_pkg::CODE_DATA_MODE) dm <= 1'b1;
    else if (cmd_valid && cmd_byte == bac_pkg::CODE_CMD_MODE) dm <= 1'b0;
  end
  always_ff @(posedge I_CLOCK) begin
    wr_q <= cfg_wr && !I_SYS_RST;
    rd_q <= cfg_rd && !I_SYS_RST;
    prev <= cmd_byte;
  end
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      store[0] <= bac_pkg::DEF_UNUSED;
      store[1] <= bac_pkg::DEF_SLEW;
      store[2] <= bac_pkg::DEF_PROG;
      store[3] <= bac_pkg::DEF_SPU;
      store[4] <= bac_pkg::DEF_W1LOW;
      store[5] <= bac_pkg::DEF_SAMPLE;
      store[6] <= bac_pkg::DEF_LOAD;
      store[7] <= bac_pkg::DEF_BAUD;
    end else if (cfg_wr) store[cmd_byte[6:4]] <= cmd_byte[3:1];
  end
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);
  AST_WR_ECHO: assert property (wr_q |-> rsp_valid && rsp_byte == {prev[7:1], 1'b0})
    else $error("write echo mismatch");
  AST_RD_ECHO: assert property (rd_q |-> rsp_valid && rsp_byte[7:4] == prev[7:4] && !rsp_byte[0])
    else $error("read echo mismatch");
  AST_RD_VALUE: assert property (rd_q |-> rsp_byte[3:1] == store[prev[3:1]])
    else $error("read value mismatch");
  AST_NEW_RATE: assert property (wr_q && prev[6:4] == 3'h7 |-> rsp_rate == prev[2:1])
    else $error("baud answer at old rate");
  AST_RATE_CAUSE: assert property ($changed(rsp_rate) |-> wr_q && prev[6:4] == 3'h7)
    else $error("rate changed without baud write");
  AST_QUIET: assert property (quiet |=> !rsp_valid)
    else $error("answer to mode or malformed byte");
  AST_RSP_HOLD: assert property (!rsp_valid |-> $stable(rsp_byte))
    else $error("response byte changed without answer");
  AST_RESET: assert property (disable iff (1'b0) I_SYS_RST |=> rsp_rate == 2'h0 && !rsp_valid)
    else $error("reset state wrong");
  cover property (wr_q && prev[6:4] == 3'h7);
  cover property (rd_q);
  cover property (dm && cmd_valid);
  cover property ($changed(rsp_rate));
endmodule

// File: tb/tb_bus_adapter_config_commands.sv
// Testbench joining host end and adapter end over the link
`timescale 1ns/1ps
module tb_bus_adapter_config_commands;
  logic clk, rst = 1'b1, wr_req = 1'b0, rd_req = 1'b0, on_req = 1'b0, off_req = 1'b0;
  logic data_req = 1'b0, stay = 1'b0, flex = 1'b0, pulse = 1'b0, pin = 1'b1, brv = 1'b0;
  logic [2:0] wp = 3'h0, wv = 3'h0, rp = 3'h0;
  logic [7:0] db = 8'h00, brb = 8'h00, h_rb, bb, last_rsp;
  logic busy, refused, h_rv, pass_done, dmode, accel, bbv, term, flex_en, slew_en, rise_en;
  logic prog_unl, spu_unl, rinv;
  logic [1:0] rsel;
  logic [2:0] par [1:7];
  logic [2:0] ex_par [1:7];
  int err_count = 0, n_tests = 0, rsp_n = 0, ref_n = 0, pass_n = 0, term_n = 0, bus_n = 0, r0;
  bac_link_if i_bac_link_if ();
  bac_host i_bac_host (.I_CLOCK(clk), .I_SYS_RST(rst), .I_WR_REQ(wr_req), .I_WR_PARAM(wp),
    .I_WR_VALUE(wv), .I_STAY_CMD(stay), .I_RD_REQ(rd_req), .I_RD_PARAM(rp),
    .I_ACCEL_ON_REQ(on_req), .I_ACCEL_OFF_REQ(off_req), .I_DATA_REQ(data_req),
    .I_DATA_BYTE(db), .O_BUSY(busy), .O_REFUSED(refused), .O_RSP_VALID(h_rv),
    .O_RSP_BYTE(h_rb), .O_PASS_DONE(pass_done), .link(i_bac_link_if));
  bac_device i_bac_device (.I_CLOCK(clk), .I_SYS_RST(rst), .I_FLEX_SPEED(flex),
    .I_PULSE_ACTIVE(pulse), .I_BUS_RSP_VALID(brv), .I_BUS_RSP_BYTE(brb),
    .I_SERIAL_POLARITY_SELECT_PIN(pin), .O_DATA_MODE(dmode), .O_SEARCH_ACCEL(accel),
    .O_BUS_BYTE_VALID(bbv), .O_BUS_BYTE(bb), .O_PULSE_TERMINATE(term),
    .O_FALLDOWN_EDGE_RATE_PARAM(par[1]), .O_PROGRAM_PULSE_LENGTH_PARAM(par[2]),
    .O_STRONG_PULLUP_LENGTH_PARAM(par[3]), .O_WRITE_ONE_LOW_PARAM(par[4]),
    .O_SAMPLE_OFFSET_RECOVERY_PARAM(par[5]), .O_PULLDOWN_LOAD_PARAM(par[6]),
    .O_HOST_SERIAL_RATE_PARAM(par[7]), .O_FLEX_TIMING_EN(flex_en),
    .O_FALL_SLEW_LIMIT_EN(slew_en), .O_RISE_SHAPE_EN(rise_en), .O_PROG_UNLIMITED(prog_unl),
    .O_SPU_UNLIMITED(spu_unl), .O_SERIAL_RATE_SEL(rsel), .O_RXD_INVERT(rinv),
    .link(i_bac_link_if));
  bac_props i_bac_props (.I_CLOCK(clk), .I_SYS_RST(rst),
    .cmd_valid(i_bac_link_if.cmd_valid), .cmd_byte(i_bac_link_if.cmd_byte),
    .rsp_valid(i_bac_link_if.rsp_valid), .rsp_byte(i_bac_link_if.rsp_byte),
    .rsp_rate(i_bac_link_if.rsp_rate));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (h_rv) begin
      rsp_n++;
      last_rsp = h_rb;
    end
    if (refused) ref_n++;
    if (pass_done) pass_n++;
    if (term) term_n++;
    if (bbv) bus_n++;
  end
  // Engine stand-in answers every forwarded byte one cycle later
  always @(negedge clk) begin
    brv <= bbv;
    brb <= ~bb;
  end
  task automatic complete_run();
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // Kinds: 0 write, 1 read, 2 accel on, 3 accel off, 4 raw byte
  task automatic issue(input int k);
    int n;
    n = 0;
    @(negedge clk);
    case (k)
      0: wr_req = 1'b1;
      1: rd_req = 1'b1;
      2: on_req = 1'b1;
      3: off_req = 1'b1;
      default: data_req = 1'b1;
    endcase
    @(negedge clk);
    {wr_req, rd_req, on_req, off_req, data_req} = 5'h00;
    while (busy !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) chk("busy timeout", 8'h00, 8'h01);
    // Lets the one-cycle-late answer and parameter outputs land
    repeat (4) @(negedge clk);
  endtask
  task automatic wr(input logic [2:0] p, input logic [2:0] v, input logic s);
    wp = p;
    wv = v;
    stay = s;
    issue(0);
  endtask
  task automatic chk_par();
    for (int i = 1; i < 8; i++) chk("param", {5'h00, ex_par[i]}, {5'h00, par[i]});
  endtask
  // Holds reset three cycles and expects the power-on codes afterwards
  task automatic reset_dut();
    rst = 1'b1;
    for (int i = 1; i < 8; i++) ex_par[i] = 3'h0;
    ex_par[2] = 3'h4;
    ex_par[3] = 3'h4;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  initial begin
    reset_dut();
    chk_par();
    chk("rise shaping", 8'h01, {7'h00, rise_en});
    chk("rxd invert", {7'h00, pin}, {7'h00, rinv});
    for (int p = 1; p < 8; p++) begin
      rp = 3'(p);
      issue(1);
      chk("read", {4'h0, ex_par[p], 1'b0}, last_rsp);
    end
    flex = 1'b1;
    repeat (3) @(negedge clk);
    chk("flex enables", 8'h00, {6'h00, flex_en, slew_en});
    wr(3'h1, 3'h4, 1'b0);
    ex_par[1] = 3'h4;
    chk("flex enables", 8'h03, {6'h00, flex_en, slew_en});
    flex = 1'b0;
    repeat (3) @(negedge clk);
    chk("flex enables", 8'h00, {6'h00, flex_en, slew_en});
    for (int p = 1; p < 8; p++) begin
      wr(3'(p), 3'(8 - p), 1'b1);
      ex_par[p] = 3'(8 - p);
      chk("write echo", {1'b0, 3'(p), 3'(8 - p), 1'b0}, last_rsp);
      chk_par();
      rp = 3'(p);
      issue(1);
      chk("read back", {4'h0, ex_par[p], 1'b0}, last_rsp);
    end
    for (int v = 0; v < 8; v++) begin
      pin = v[0];
      wr(3'h7, 3'(v), 1'b0);
      chk("rate", {6'h00, v[1:0]}, {6'h00, rsel});
      chk("rxd invert", {7'h00, pin ^ v[2]}, {7'h00, rinv});
    end
    ex_par[7] = 3'h7;
    r0 = rsp_n;
    wr(3'h3, 3'h6, 1'b1);
    chk("refused", 8'h01, 8'(ref_n));
    wr(3'h2, 3'h7, 1'b0);
    chk("refused", 8'h02, 8'(ref_n));
    chk("refused sent", 8'(r0), 8'(rsp_n));
    chk_par();
    wr(3'h2, 3'h7, 1'b1);
    wr(3'h3, 3'h7, 1'b1);
    chk("unlimited", 8'h03, {6'h00, prog_unl, spu_unl});
    pulse = 1'b1;
    db = bac_pkg::CODE_TERMINATE;
    issue(4);
    chk("terminate", 8'h01, 8'(term_n));
    r0 = rsp_n;
    db = 8'h7E;
    issue(4);
    chk("malformed answered", 8'(r0), 8'(rsp_n));
    issue(2);
    chk("accel on", 8'h03, {6'h00, accel, dmode});
    for (int i = 0; i < 16; i++) begin
      db = (i == 0) ? bac_pkg::CODE_TERMINATE : 8'(i);
      issue(4);
      chk("bus answer", ~db, last_rsp);
    end
    chk("bus bytes", 8'h10, 8'(bus_n));
    chk("pass done", 8'h01, 8'(pass_n));
    chk("terminate", 8'h01, 8'(term_n));
    issue(3);
    chk("accel off", 8'h00, {6'h00, accel, dmode});
    pulse = 1'b0;
    // Master reset from data mode with every setting moved
    issue(2);
    reset_dut();
    chk_par();
    chk("mode after reset", 8'h00, {6'h00, accel, dmode});
    chk("rxd invert", {7'h00, pin}, {7'h00, rinv});
    complete_run();
  end
  // Whole run is under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule
